// ### shared/ssp_pkg.sv
// shared constants, register map and carrier types of the synchronous serial shift port
package ssp_pkg;

	localparam int          APB_AW         = 12;

	// register indices; the byte address on the bus is four times the index
	localparam logic [7:0]  IDX_CONTROL    = 8'hf1;
	localparam logic [7:0]  IDX_BUFFER     = 8'hf2;
	localparam logic [7:0]  IDX_RX_FIFO    = 8'hf3;
	localparam logic [7:0]  IDX_PRESCALER  = 8'hf4;
	localparam logic [7:0]  IDX_STATUS     = 8'hf5;

	localparam logic [7:0]  CONTROL_RESET  = 8'h00;
	localparam logic [7:0]  PRESCALE_RESET = 8'h00;
	localparam logic [7:0]  BUFFER_RESET   = 8'h00;

	// internal shift clock source is the oscillator divided by this figure
	localparam int          OSC_DIV        = 4;
	localparam int          BITS_PER_BYTE  = 8;
	localparam logic [2:0]  LAST_BIT       = 3'h7;

	// control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic lsb_first;   // 7: 0 msb first, 1 lsb first
		logic ext_clk;     // 6: 0 internal prescaler, 1 clock pin input
		logic tx_rx;       // 5: 0 receive only, 1 transmit and receive
		logic edge_rise;   // 4: 0 transmit on falling edge, 1 on rising edge
		logic start;       // 3: write one to start, always reads zero
		logic shift_en;    // 2: data shifter enable
		logic int_en;      // 1: interrupt enable
		logic pending;     // 0: transfer complete
	} ctrl_t;

	// status register layout
	typedef struct packed {
		logic [2:0] unused;
		logic [4:0] fifo_level;
		logic [1:0] unused_lo;
		logic       fifo_nonempty;
		logic       busy;
	} status_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN,
		ST_PUSH
	} shift_state_t;

	function automatic logic [APB_AW-1:0] reg_addr(input logic [7:0] idx);
		return {2'h0, idx, 2'h0};
	endfunction

	// pclk cycles for half a shift clock period
	function automatic logic [9:0] half_period(input logic [7:0] p);
		return 10'((OSC_DIV / 2) * (int'(p) + 1));
	endfunction

endpackage

// ### src/sync_serial_shift_port.sv
// serial shift port with apb registers, receive fifo and the fifo module itself
//
// Local design decision: the APB slave port.

////////////////////////////////////////////////////////////////////////////////

module rx_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic              pclk,       // clock
	input  wire logic              presetn,    // async reset, active low
	input  wire logic              in_valid,   // write side offers a word
	output logic                   in_ready,   // room for a word
	input  wire logic [WIDTH-1:0]  in_data,    // word to store
	output logic                   out_valid,  // a word waits
	input  wire logic              out_ready,  // reader takes the word
	output logic [WIDTH-1:0]       out_data,   // oldest word
	output logic [$clog2(DEPTH):0] level       // words held
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (DEPTH < 2 || WIDTH < 1) begin : g_check
		$error("rx_byte_fifo needs DEPTH of at least 2 and WIDTH of at least 1");
	end

	logic [WIDTH-1:0]    mem [DEPTH];
	logic [PW-1:0]       wr_ptr;
	logic [PW-1:0]       rd_ptr;
	logic [PW-1:0]       next_wr_ptr;
	logic [PW-1:0]       next_rd_ptr;
	logic [$clog2(DEPTH):0] next_level;
	logic                push;
	logic                pop;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready  = (level != ($clog2(DEPTH) + 1)'(DEPTH));
	assign out_valid = (level != '0);
	assign out_data  = mem[rd_ptr];

	always_comb begin
		push        = in_valid & in_ready;
		pop         = out_valid & out_ready;
		next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
		next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
		next_level  = level;
		if (push & ~pop) begin
			next_level = level + 1'b1;
		end else if (pop & ~push) begin
			next_level = level - 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			level  <= next_level;
		end
	end

	// storage needs no reset: a word is only read after it was written
	always_ff @(posedge pclk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule // rx_byte_fifo

////////////////////////////////////////////////////////////////////////////////

module sync_serial_shift_port #(
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic                        pclk,     // clock, 250 MHz
	input  wire logic                        presetn,  // async reset, active low
	input  wire logic                        psel,     // apb select
	input  wire logic                        penable,  // apb access phase
	input  wire logic                        pwrite,   // apb direction
	input  wire logic [ssp_pkg::APB_AW-1:0]  paddr,    // apb byte address
	input  wire logic [31:0]                 pwdata,   // apb write data
	output logic      [31:0]                 prdata,   // apb read data
	output logic                             pready,   // apb ready
	output logic                             pslverr,  // unmapped address
	input  wire logic                        sck_in,   // shift clock pin input
	output logic                             sck_out,  // shift clock pin output
	output logic                             sck_oe,   // shift clock pin enable
	input  wire logic                        si,       // serial data input pin
	output logic                             so,       // serial data output pin
	output logic                             so_oe,    // serial output enable
	output logic                             irq       // transfer done request
);
	if (FIFO_DEPTH < 2 || FIFO_DEPTH > 16) begin : g_check
		$error("FIFO_DEPTH must lie between 2 and 16 to fit the status level field");
	end

	ssp_pkg::ctrl_t        ctrl;
	ssp_pkg::ctrl_t        next_ctrl;
	logic [7:0]            prescaler;
	logic [7:0]            next_prescaler;
	logic [7:0]            buffer;
	logic [7:0]            next_buffer;
	ssp_pkg::shift_state_t state;
	ssp_pkg::shift_state_t next_state;
	logic [2:0]            cnt;
	logic [2:0]            next_cnt;
	logic [9:0]            div;
	logic [9:0]            next_div;
	logic                  sck_int;
	logic                  next_sck_int;
	logic                  so_bit;
	logic                  next_so_bit;
	logic [31:0]           next_prdata;
	logic                  si_s1;
	logic                  si_s2;
	logic                  sck_s1;
	logic                  sck_s2;
	logic                  sck_s3;

	logic                  fifo_in_valid;
	logic                  fifo_in_ready;
	logic                  fifo_out_valid;
	logic                  fifo_out_ready;
	logic [7:0]            fifo_out_data;
	logic [$clog2(FIFO_DEPTH):0] fifo_level;

	logic                  wr;
	logic                  rd;
	logic                  setup;
	logic                  mapped;
	logic                  int_tick;
	logic                  rise;
	logic                  fall;
	logic                  sample_edge;
	logic                  tx_edge;
	ssp_pkg::status_t      status;

	////////////////////////////////////////////////////////////////////////////

	rx_byte_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (buffer),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data),
		.level     (fifo_level)
	);

	////////////////////////////////////////////////////////////////////////////

	// zero wait states: every access phase completes at once
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	// the pin is driven only while the internal source is chosen
	assign sck_out = sck_int;
	assign sck_oe  = ~ctrl.ext_clk;
	assign so      = so_bit;
	assign so_oe   = ctrl.tx_rx & ctrl.shift_en;
	assign irq     = ctrl.pending & ctrl.int_en;

	always_comb begin
		setup  = psel & ~penable;
		wr     = psel & penable & pwrite;
		rd     = psel & penable & ~pwrite;
		mapped = (paddr == ssp_pkg::reg_addr(ssp_pkg::IDX_CONTROL))
			| (paddr == ssp_pkg::reg_addr(ssp_pkg::IDX_BUFFER))
			| (paddr == ssp_pkg::reg_addr(ssp_pkg::IDX_RX_FIFO))
			| (paddr == ssp_pkg::reg_addr(ssp_pkg::IDX_PRESCALER))
			| (paddr == ssp_pkg::reg_addr(ssp_pkg::IDX_STATUS));

		// busy, fifo nonempty and fifo level let software poll without the request
		status               = '0;
		status.busy          = (state != ssp_pkg::ST_IDLE);
		status.fifo_nonempty = fifo_out_valid;
		status.fifo_level    = 5'(fifo_level);

		// shift clock edges, seen only while a byte is in flight
		// si reaches the shifter two pclk late, so a zero prescaler (half period
		// of two pclk) takes the previous bit; one or more leaves a clean margin
		// against a peer that answers on the opposite edge
		int_tick = (state != ssp_pkg::ST_IDLE) & ~ctrl.ext_clk
			& (div == ssp_pkg::half_period(prescaler) - 10'h001);
		// an external clock is seen two pclk after the pin moves, so its
		// half period must stay above about four pclk
		if (ctrl.ext_clk) begin
			rise = (state == ssp_pkg::ST_RUN) & sck_s2 & ~sck_s3;
			fall = (state == ssp_pkg::ST_RUN) & ~sck_s2 & sck_s3;
		end else begin
			rise = int_tick & ~sck_int;
			fall = int_tick & sck_int;
		end
		sample_edge = ctrl.edge_rise ? fall : rise;
		tx_edge     = ctrl.edge_rise ? rise : fall;
	end

	always_comb begin
		next_ctrl      = ctrl;
		next_prescaler = prescaler;
		next_buffer    = buffer;
		next_state     = state;
		next_cnt       = cnt;
		next_div       = div;
		next_sck_int   = sck_int;
		next_so_bit    = so_bit;
		next_prdata    = prdata;
		fifo_in_valid  = 1'b0;
		fifo_out_ready = 1'b0;

		// read data is latched in the setup cycle so it leaves a flip-flop
		if (setup & ~pwrite) begin
			if (paddr == ssp_pkg::reg_addr(ssp_pkg::IDX_CONTROL)) begin
				next_prdata = {24'h000000, ctrl};
			end else if (paddr == ssp_pkg::reg_addr(ssp_pkg::IDX_BUFFER)) begin
				next_prdata = {24'h000000, buffer};
			end else if (paddr == ssp_pkg::reg_addr(ssp_pkg::IDX_RX_FIFO)) begin
				next_prdata = {24'h000000, fifo_out_valid ? fifo_out_data : 8'h00};
			end else if (paddr == ssp_pkg::reg_addr(ssp_pkg::IDX_PRESCALER)) begin
				next_prdata = {24'h000000, prescaler};
			end else if (paddr == ssp_pkg::reg_addr(ssp_pkg::IDX_STATUS)) begin
				next_prdata = {20'h00000, status};
			end else begin
				// unmapped addresses read as zero; pslverr flags them
				next_prdata = 32'h00000000;
			end
		end

		// the head word was shown in setup; it is removed as the read completes
		if (rd & (paddr == ssp_pkg::reg_addr(ssp_pkg::IDX_RX_FIFO))) begin
			fifo_out_ready = 1'b1;
		end

		case (state)
			ssp_pkg::ST_RUN: begin
				next_div = int_tick ? 10'h000 : div + 10'h001;
				if (int_tick) begin
					next_sck_int = ~sck_int;
				end
				if (sample_edge) begin
					next_buffer = ctrl.lsb_first ? {si_s2, buffer[7:1]}
						: {buffer[6:0], si_s2};
					next_cnt = cnt + 3'h1;
					if (cnt == ssp_pkg::LAST_BIT) begin
						next_state = ssp_pkg::ST_PUSH;
					end
				end
				if (tx_edge) begin
					next_so_bit = ctrl.lsb_first ? buffer[0] : buffer[7];
				end
				// clearing the enable abandons the byte without setting pending
				if (~ctrl.shift_en) begin
					next_state   = ssp_pkg::ST_IDLE;
					next_sck_int = 1'b1;
				end
			end
			ssp_pkg::ST_PUSH: begin
				// with transmit on the rising edge the byte ends low; the clock
				// finishes that half period before the byte is handed on
				if (~sck_int) begin
					next_div = int_tick ? 10'h000 : div + 10'h001;
					if (int_tick) begin
						next_sck_int = 1'b1;
					end
				end else begin
					// a full fifo holds the byte here and stalls the next start
					fifo_in_valid = 1'b1;
					if (fifo_in_ready) begin
						next_state = ssp_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				// idle: clock parked high and divider cleared
				next_div     = 10'h000;
				next_sck_int = 1'b1;
			end
		endcase

		if (wr) begin
			if (paddr == ssp_pkg::reg_addr(ssp_pkg::IDX_CONTROL)) begin
				next_ctrl         = ssp_pkg::ctrl_t'(pwdata[7:0]);
				next_ctrl.start   = 1'b0;
				next_ctrl.pending = ctrl.pending & pwdata[0];
				if (pwdata[3] & pwdata[2] & (state == ssp_pkg::ST_IDLE)) begin
					next_state   = ssp_pkg::ST_RUN;
					next_cnt     = 3'h0;
					next_div     = 10'h000;
					next_sck_int = 1'b1;
					// first bit goes out at once so the peer can take it on the first edge
					next_so_bit  = pwdata[7] ? buffer[0] : buffer[7];
				end
			end else if (paddr == ssp_pkg::reg_addr(ssp_pkg::IDX_BUFFER)) begin
				// a write while busy would corrupt the byte in flight
				if (state == ssp_pkg::ST_IDLE) begin
					next_buffer = pwdata[7:0];
				end
			end else if (paddr == ssp_pkg::reg_addr(ssp_pkg::IDX_PRESCALER)) begin
				// takes effect at once, even within a byte in flight
				next_prescaler = pwdata[7:0];
			end
		end

		// completion sets pending after any clear in the same cycle
		if ((state == ssp_pkg::ST_PUSH) & fifo_in_valid & fifo_in_ready) begin
			next_ctrl.pending = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl      <= ssp_pkg::ctrl_t'(ssp_pkg::CONTROL_RESET);
			prescaler <= ssp_pkg::PRESCALE_RESET;
			buffer    <= ssp_pkg::BUFFER_RESET;
			state     <= ssp_pkg::ST_IDLE;
			cnt       <= 3'h0;
			div       <= 10'h000;
			sck_int   <= 1'b1;
			so_bit    <= 1'b0;
			prdata    <= 32'h00000000;
		end else begin
			ctrl      <= next_ctrl;
			prescaler <= next_prescaler;
			buffer    <= next_buffer;
			state     <= next_state;
			cnt       <= next_cnt;
			div       <= next_div;
			sck_int   <= next_sck_int;
			so_bit    <= next_so_bit;
			prdata    <= next_prdata;
		end
	end

	// pin synchronisers; the third clock stage only feeds edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			si_s1  <= 1'b0;
			si_s2  <= 1'b0;
			sck_s1 <= 1'b1;
			sck_s2 <= 1'b1;
			sck_s3 <= 1'b1;
		end else begin
			si_s1  <= si;
			si_s2  <= si_s1;
			sck_s1 <= sck_in;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
		end
	end
endmodule // sync_serial_shift_port

// ### testbench/ssp_assertions.sv
// concurrent checks on the serial shift port pins and apb traffic
module ssp_checker (
	input wire logic                       pclk,    // clock
	input wire logic                       presetn, // reset, active low
	input wire logic                       psel,    // apb select
	input wire logic                       penable, // apb access
	input wire logic                       pwrite,  // apb direction
	input wire logic [ssp_pkg::APB_AW-1:0] paddr,   // apb address
	input wire logic [31:0]                pwdata,  // write data
	input wire logic [31:0]                prdata,  // read data
	input wire logic                       sck_out, // shift clock out
	input wire logic                       sck_oe,  // shift clock enable
	input wire logic                       so,      // serial out
	input wire logic                       so_oe,   // serial out enable
	input wire logic                       irq      // request
);
	timeunit 1ns;
	timeprecision 1ps;
	ssp_pkg::ctrl_t sh;
	logic [7:0]     ps;
	logic [9:0]     lowcnt;
	logic           wr_ctrl;
	assign wr_ctrl = psel && penable && pwrite && paddr == 12'h3c4;
	// shadow of software writes; pending is ignored since hardware also sets it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh <= '0;
			ps <= 8'h00;
			lowcnt <= 10'h000;
		end else begin
			if (wr_ctrl) sh <= ssp_pkg::ctrl_t'(pwdata[7:0]);
			if (psel && penable && pwrite && paddr == 12'h3d0) ps <= pwdata[7:0];
			lowcnt <= sck_out ? 10'h000 : lowcnt + 10'h001;
		end
	end
////////////////////////////////////////
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_oe_mode: assert property (so_oe == (sh.tx_rx && sh.shift_en))
		else $error("serial out enable wrong for mode");
	a_clk_dir: assert property (sck_oe == !sh.ext_clk)
		else $error("clock pin direction wrong");
	a_irq_gate: assert property (irq |-> sh.int_en)
		else $error("request without enable");
	a_clk_idle: assert property ((!sh.shift_en) [*3] |-> sck_out)
		else $error("shift clock moves while disabled");
	a_half_per: assert property ($rose(sck_out) && !sh.ext_clk |->
		lowcnt == {1'b0, ps, 1'b0} + 10'h002) else $error("shift clock low time wrong");
	a_so_edge: assert property ($changed(so) && so_oe && !sh.ext_clk && !$past(wr_ctrl)
		|-> sck_out == sh.edge_rise) else $error("serial out changed on wrong edge");
	a_pend_hold: assert property (irq && !wr_ctrl |=> irq)
		else $error("pending dropped without a write");
	a_start_zero: assert property (psel && penable && !pwrite && paddr == 12'h3c4
		|-> prdata[3] == 1'b0 && prdata[31:8] == 24'h0) else $error("start bit reads one");
	a_reset_vals: assert property ($rose(presetn) |-> !irq && !so_oe && sck_oe)
		else $error("outputs wrong after reset");
	c_irq: cover property ($rose(irq));
	c_lsb: cover property ($rose(sck_out) && sh.lsb_first);
	c_rise: cover property ($changed(so) && sh.edge_rise);
endmodule // ssp_checker

// ### testbench/serial_peer_model.sv
// external serial peripheral: feeds si, captures so, can drive the clock pin
module serial_peer_model (
	input wire logic       pclk,    // bench clock
	input wire logic       frame,   // a byte is in progress
	input wire logic       ext,     // peripheral drives the clock
	input wire logic       erise,   // 1: sample on falling edge
	input wire logic       lsb,     // lsb first
	input wire logic [7:0] send,    // byte for si
	input wire logic       sck_pin, // level on the clock pin
	input wire logic       so,      // serial out of the port
	output logic           si,      // serial in of the port
	output logic           sck_drv, // clock when driving the pin
	output logic [7:0]     got      // byte seen on so
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       prev;
	logic [3:0] n;
	logic [3:0] div;
	logic [4:0] tog;
	initial begin
		si = 1'b0;
		sck_drv = 1'b1;
		prev = 1'b1;
	end
	always @(posedge pclk) begin
		prev <= sck_pin;
		if (!frame) begin
			n <= 4'h0;
			div <= 4'h0;
			tog <= 5'h00;
			sck_drv <= 1'b1;
			// released line keeps moving so a stale bit never looks valid
			si <= ~si;
		end else begin
			if (ext && tog < 5'h10) begin
				div <= (div == 4'h7) ? 4'h0 : div + 4'h1;
				if (div == 4'h7) begin
					sck_drv <= ~sck_drv;
					tog <= tog + 5'h01;
				end
			end
			if (sck_pin != prev && sck_pin != erise) begin
				got <= lsb ? {so, got[7:1]} : {got[6:0], so};
				n <= n + 4'h1;
			end else if (sck_pin != prev || n == 4'h0)
				si <= send[lsb ? n[2:0] : 3'h7 - n[2:0]];
		end
	end
endmodule // serial_peer_model

// ### testbench/sync_serial_shift_port_tb.sv
// self-checking bench: apb master, transfer loop, fifo fill and drain
module sync_serial_shift_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                       pclk = 1'b0;
	logic                       presetn = 1'b0;
	logic                       psel = 1'b0;
	logic                       penable = 1'b0;
	logic                       pwrite = 1'b0;
	logic [ssp_pkg::APB_AW-1:0] paddr = '0;
	logic [31:0]                pwdata = 32'h0;
	logic [31:0]                prdata, rd;
	logic                       pready, pslverr, sck_out, sck_oe, so, so_oe, irq;
	logic                       si, sck_drv, sck_pin, err;
	logic                       frame = 1'b0, ext = 1'b0, erise = 1'b0, lsb = 1'b0;
	logic [7:0]                 send = 8'h00, got;
	logic [7:0]                 mdl_q[$];
	int                         n_fail = 0, checked = 0;
	always #2 pclk = ~pclk;
	assign sck_pin = sck_oe ? sck_out : sck_drv;
	sync_serial_shift_port #(.FIFO_DEPTH(16)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_in(sck_pin),
		.sck_out(sck_out), .sck_oe(sck_oe), .si(si), .so(so), .so_oe(so_oe), .irq(irq));
	serial_peer_model peer_u (.pclk(pclk), .frame(frame), .ext(ext), .erise(erise),
		.lsb(lsb), .send(send), .sck_pin(sck_pin), .so(so), .si(si), .sck_drv(sck_drv),
		.got(got));
////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k == 20) begin
			n_fail++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// one byte each way, receive only for m 5; m picks order, edge, clock source and mode
	task automatic xfer(input int m, input logic done_exp);
		logic [7:0] c, txb, sb;
		int         k;
		txb = 8'($urandom);
		sb = 8'($urandom);
		// zero is left out: the input synchroniser needs a half period of four pclk
		apb(1'b1, ssp_pkg::IDX_PRESCALER, 8'($urandom_range(3, 1)));
		apb(1'b1, ssp_pkg::IDX_BUFFER, txb);
		c = {m[0], m == 4, m != 5, m[1], 1'b1, 1'b1, m[2] | m[0], 1'b0};
		lsb <= m[0];
		erise <= m[1];
		ext <= (m == 4);
		send <= sb;
		frame <= 1'b1;
		apb(1'b1, ssp_pkg::IDX_CONTROL, c);
		// a stalled byte never sets pending: give it time, then look once
		if (!done_exp) repeat (300) @(posedge pclk);
		k = 0;
		do begin
			apb(1'b0, ssp_pkg::IDX_CONTROL, 8'h00);
			k++;
		end while (done_exp && rd[0] !== 1'b1 && k < 120);
		if (done_exp && rd[0] !== 1'b1) begin
			n_fail++;
			end_sim();
		end
		frame <= 1'b0;
		chk(rd[7:0], (c & 8'hf6) | {7'h0, done_exp});
		chk(irq, c[1] & done_exp);
		if (m != 5) chk(got, txb);
		mdl_q.push_back(sb);
		apb(1'b1, ssp_pkg::IDX_CONTROL, c & 8'hf6);
		chk(irq, 1'b0);
	endtask
////////////////////////////////////////
	initial begin
		void'($urandom(32'h3fd5));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({irq, so_oe, sck_oe, sck_out}, 4'h3);
		apb(1'b0, ssp_pkg::IDX_CONTROL, 8'h00);
		chk(rd, 32'h0);
		apb(1'b1, ssp_pkg::IDX_CONTROL, 8'h08);
		apb(1'b0, ssp_pkg::IDX_STATUS, 8'h00);
		chk({rd[0], sck_out}, 2'h1);
		apb(1'b1, ssp_pkg::IDX_CONTROL, 8'h01);
		apb(1'b0, ssp_pkg::IDX_CONTROL, 8'h00);
		chk(rd, 32'h0);
		apb(1'b0, 8'h10, 8'h00);
		chk({err, rd[7:0]}, 9'h100);
		// sixteen bytes fill the fifo; the seventeenth must wait for room
		for (int i = 0; i < 17; i++) xfer(i % 6, i < 16);
		apb(1'b0, ssp_pkg::IDX_STATUS, 8'h00);
		chk(rd[8:0], 9'h103);
		while (mdl_q.size() > 0) begin
			apb(1'b0, ssp_pkg::IDX_RX_FIFO, 8'h00);
			chk(rd[7:0], mdl_q.pop_front());
		end
		apb(1'b0, ssp_pkg::IDX_CONTROL, 8'h00);
		chk(rd[0], 1'b1);
		apb(1'b0, ssp_pkg::IDX_RX_FIFO, 8'h00);
		chk(rd, 32'h0);
		end_sim();
	end
endmodule // sync_serial_shift_port_tb

bind sync_serial_shift_port ssp_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.sck_out(sck_out), .sck_oe(sck_oe), .so(so), .so_oe(so_oe), .irq(irq));
